// ===== hdl/srls_core.sv
// Speed command limiting, ramping, zero clamp and status outputs.
// Assumes synchronous inputs on pclk and signed rpm speed values.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module srls_core #(
   parameter int TICK_CYC = srls_pkg::TICK_CYCLES,
   parameter logic [12:0] MOTOR_MAX_RPM = 13'h1770
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Speed inputs
   input wire logic signed [13:0] analog_speed_cmd,
   input wire logic signed [13:0] actual_speed,
   input wire logic signed [13:0] filtered_speed,
   input wire logic zero_clamp_input,
   // Command and status outputs
   output logic signed [13:0] speed_cmd_out,
   output logic position_lock_out,
   output logic rotation_detect_out,
   output logic standstill_out,
   output logic speed_match_out,
   output logic speed_reached_out,
   output logic digital_out
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] accel_time_setting;
      logic [15:0] decel_time_setting;
      logic [12:0] max_speed_limit;
      logic [12:0] forward_speed_limit;
      logic [12:0] reverse_speed_limit;
      logic [1:0] clamp_mode_select;
      logic [12:0] clamp_speed_threshold;
      logic [12:0] rotation_threshold;
      logic [12:0] standstill_threshold;
      logic [12:0] match_threshold;
      logic [12:0] reached_threshold;
      logic [7:0] output_function_select;
      logic output_polarity_select;
      logic speed_source_select;
      logic signed [13:0] digital_cmd;
      logic [31:0] tick_cnt;
      logic signed [31:0] ramp_acc;
      logic signed [13:0] ramp;
      logic signed [13:0] cmd_out;
      logic lock;
      logic [4:0] stat;
      logic dout;
   } srls_state_t;

   srls_state_t cur_r;
   srls_state_t cur_nxt;

   function automatic logic [12:0] mag(input logic signed [13:0] v);
      mag = v[13] ? 13'((-v)) : v[12:0];
   endfunction

   function automatic logic [12:0] min3(input logic [12:0] a,
         input logic [12:0] b, input logic [12:0] c);
      logic [12:0] m;
      m = (a < b) ? a : b;
      min3 = (m < c) ? m : c;
   endfunction

   function automatic logic [12:0] sat(input logic [31:0] v,
         input logic [12:0] hi);
      sat = (v > 32'(hi)) ? hi : v[12:0];
   endfunction

   logic signed [13:0] src_cmd;
   logic [12:0] fwd_cap;
   logic [12:0] rev_cap;
   logic signed [13:0] target;
   logic [15:0] step_time;
   logic signed [31:0] diff;
   logic signed [31:0] rate;
   logic [31:0] diffmag;
   logic clamp_hit;
   logic lock_now;
   logic force_zero;
   logic [12:0] fmag;
   logic [12:0] amag;
   logic [12:0] tmag;
   logic sel_status;
   logic apb_wr;
   logic [31:0] rd;
   logic stopped;

   always_comb begin
      cur_nxt = cur_r;
      apb_wr = psel && penable && pwrite;
      stopped = (cur_r.ramp == 14'sh0000) && (actual_speed == 14'sh0000);
      // Register writes
      if (apb_wr) begin
         unique case (paddr)
            srls_pkg::ADDR_ACCEL: cur_nxt.accel_time_setting = pwdata[15:0];
            srls_pkg::ADDR_DECEL: cur_nxt.decel_time_setting = pwdata[15:0];
            srls_pkg::ADDR_MAXLIM: cur_nxt.max_speed_limit =
               sat(pwdata, srls_pkg::MAXLIM_MAX);
            srls_pkg::ADDR_FWDLIM: cur_nxt.forward_speed_limit =
               sat(pwdata, srls_pkg::DIRLIM_MAX);
            srls_pkg::ADDR_REVLIM: cur_nxt.reverse_speed_limit =
               sat(pwdata, srls_pkg::DIRLIM_MAX);
            srls_pkg::ADDR_CLMODE: cur_nxt.clamp_mode_select = pwdata[1:0];
            srls_pkg::ADDR_CLTHR: cur_nxt.clamp_speed_threshold =
               sat(pwdata, srls_pkg::THR1000_MAX);
            srls_pkg::ADDR_ROTTHR: cur_nxt.rotation_threshold =
               sat(pwdata, srls_pkg::THR1000_MAX);
            srls_pkg::ADDR_ZSTHR: cur_nxt.standstill_threshold =
               sat(pwdata, srls_pkg::ZSTHR_MAX);
            srls_pkg::ADDR_MATTHR: cur_nxt.match_threshold =
               sat(pwdata, srls_pkg::MATTHR_MAX);
            srls_pkg::ADDR_REATHR: cur_nxt.reached_threshold =
               (pwdata < 32'(srls_pkg::REATHR_MIN)) ? srls_pkg::REATHR_MIN :
               sat(pwdata, srls_pkg::ZSTHR_MAX);
            srls_pkg::ADDR_DOSEL:
               if (pwdata >= 32'(srls_pkg::DOSEL_MIN) &&
                     pwdata <= 32'(srls_pkg::DOSEL_MAX)) begin
                  cur_nxt.output_function_select = pwdata[7:0];
               end
            srls_pkg::ADDR_DOPOL: cur_nxt.output_polarity_select = pwdata[0];
            srls_pkg::ADDR_SRCSEL:
               if (stopped) begin
                  cur_nxt.speed_source_select = pwdata[0];
               end
            srls_pkg::ADDR_DIGCMD: cur_nxt.digital_cmd = pwdata[13:0];
            default: ;
         endcase
      end
      // Register reads
      unique case (paddr)
         srls_pkg::ADDR_ACCEL: rd = 32'(cur_r.accel_time_setting);
         srls_pkg::ADDR_DECEL: rd = 32'(cur_r.decel_time_setting);
         srls_pkg::ADDR_MAXLIM: rd = 32'(cur_r.max_speed_limit);
         srls_pkg::ADDR_FWDLIM: rd = 32'(cur_r.forward_speed_limit);
         srls_pkg::ADDR_REVLIM: rd = 32'(cur_r.reverse_speed_limit);
         srls_pkg::ADDR_CLMODE: rd = 32'(cur_r.clamp_mode_select);
         srls_pkg::ADDR_CLTHR: rd = 32'(cur_r.clamp_speed_threshold);
         srls_pkg::ADDR_ROTTHR: rd = 32'(cur_r.rotation_threshold);
         srls_pkg::ADDR_ZSTHR: rd = 32'(cur_r.standstill_threshold);
         srls_pkg::ADDR_MATTHR: rd = 32'(cur_r.match_threshold);
         srls_pkg::ADDR_REATHR: rd = 32'(cur_r.reached_threshold);
         srls_pkg::ADDR_DOSEL: rd = 32'(cur_r.output_function_select);
         srls_pkg::ADDR_DOPOL: rd = 32'(cur_r.output_polarity_select);
         srls_pkg::ADDR_SRCSEL: rd = 32'(cur_r.speed_source_select);
         srls_pkg::ADDR_DIGCMD: rd = 32'(cur_r.digital_cmd);
         srls_pkg::ADDR_STATUS: rd = 32'(cur_r.stat);
         srls_pkg::ADDR_RAMPED: rd = 32'(cur_r.cmd_out);
         default: rd = 32'h0000_0000;
      endcase
      // APB: one wait-free access phase
      cur_nxt.pready = psel && !penable;
      cur_nxt.prdata = (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
      cur_nxt.pslverr = psel && !penable && (paddr[1:0] != 2'h0 ||
         paddr > srls_pkg::ADDR_RAMPED);

      // Source and limit
      src_cmd = cur_r.speed_source_select ? analog_speed_cmd :
         cur_r.digital_cmd;
      fwd_cap = min3(MOTOR_MAX_RPM, cur_r.max_speed_limit,
         cur_r.forward_speed_limit);
      rev_cap = min3(MOTOR_MAX_RPM, cur_r.max_speed_limit,
         cur_r.reverse_speed_limit);
      if (!src_cmd[13]) begin
         target = (src_cmd[12:0] > fwd_cap) ? 14'(fwd_cap) : src_cmd;
      end else begin
         target = (mag(src_cmd) > rev_cap) ? -14'(rev_cap) : src_cmd;
      end

      // Zero clamp
      tmag = mag(src_cmd);
      amag = mag(actual_speed);
      fmag = mag(filtered_speed);
      clamp_hit = zero_clamp_input &&
         (cur_r.clamp_mode_select != srls_pkg::CM_OFF);
      force_zero = 1'b0;
      lock_now = 1'b0;
      if (clamp_hit) begin
         unique case (cur_r.clamp_mode_select)
            srls_pkg::CM_FORCE: begin
               force_zero = 1'b1;
               lock_now = tmag < cur_r.clamp_speed_threshold;
            end
            srls_pkg::CM_ACTUAL: begin
               force_zero = 1'b1;
               lock_now = amag < cur_r.clamp_speed_threshold;
            end
            srls_pkg::CM_CMD: begin
               force_zero = tmag < cur_r.clamp_speed_threshold;
               lock_now = force_zero;
            end
            default: ;
         endcase
      end
      if (force_zero) begin
         target = 14'sh0000;
      end
      cur_nxt.lock = lock_now;

      // Ramp, one step per tick
      if (cur_r.tick_cnt >= 32'(TICK_CYC - 1)) begin
         cur_nxt.tick_cnt = 32'h0000_0000;
      end else begin
         cur_nxt.tick_cnt = cur_r.tick_cnt + 32'h0000_0001;
      end
      diff = 32'(target) - 32'(cur_r.ramp);
      diffmag = diff[31] ? 32'(-diff) : 32'(diff);
      // Speeding up in magnitude uses accel, slowing uses decel
      step_time = (mag(target) > mag(cur_r.ramp) &&
         (target[13] == cur_r.ramp[13] || cur_r.ramp == 14'sh0000)) ?
         cur_r.accel_time_setting : cur_r.decel_time_setting;
      // Fraction of rpm per tick held with 1/1000 resolution
      rate = 32'(srls_pkg::SPEED_UNIT_RPM);
      if (step_time == 16'h0000 || lock_now) begin
         cur_nxt.ramp = target;
         cur_nxt.ramp_acc = 32'sh0000_0000;
      end else if (cur_r.tick_cnt >= 32'(TICK_CYC - 1)) begin
         // 1000 rpm per step_time ms: add 1000000/step_time milli-rpm per tick
         cur_nxt.ramp_acc = cur_r.ramp_acc + rate * 32'(srls_pkg::SPEED_UNIT_RPM)
            / 32'(step_time);
         if (32'(cur_nxt.ramp_acc) / 32'(srls_pkg::SPEED_UNIT_RPM) >= diffmag)
            begin
            cur_nxt.ramp = target;
            cur_nxt.ramp_acc = 32'sh0000_0000;
         end else if (cur_nxt.ramp_acc >= rate) begin
            cur_nxt.ramp = diff[31] ?
               14'(cur_r.ramp - 14'(cur_nxt.ramp_acc / rate)) :
               14'(cur_r.ramp + 14'(cur_nxt.ramp_acc / rate));
            cur_nxt.ramp_acc = cur_nxt.ramp_acc % rate;
         end
      end
      cur_nxt.cmd_out = lock_now ? 14'sh0000 : cur_nxt.ramp;

      // Status
      cur_nxt.stat[srls_pkg::ST_ROT] = amag >= cur_r.rotation_threshold;
      cur_nxt.stat[srls_pkg::ST_ZERO] =
         amag < cur_r.standstill_threshold;
      cur_nxt.stat[srls_pkg::ST_MATCH] = (32'(filtered_speed) -
         32'(cur_r.cmd_out) <= $signed(32'(cur_r.match_threshold))) &&
         (32'(cur_r.cmd_out) - 32'(filtered_speed) <=
         $signed(32'(cur_r.match_threshold)));
      cur_nxt.stat[srls_pkg::ST_REACH] =
         fmag > cur_r.reached_threshold;
      cur_nxt.stat[srls_pkg::ST_LOCK] = lock_now;
      unique case (cur_r.output_function_select)
         srls_pkg::FN_ROTATE: sel_status = cur_r.stat[srls_pkg::ST_ROT];
         srls_pkg::FN_ZERO: sel_status = cur_r.stat[srls_pkg::ST_ZERO];
         srls_pkg::FN_MATCH: sel_status = cur_r.stat[srls_pkg::ST_MATCH];
         srls_pkg::FN_REACHED: sel_status = cur_r.stat[srls_pkg::ST_REACH];
         default: sel_status = 1'b0;
      endcase
      cur_nxt.dout = sel_status ^ cur_r.output_polarity_select;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_r <= '0;
         cur_r.accel_time_setting <= srls_pkg::ACCEL_RST;
         cur_r.decel_time_setting <= srls_pkg::DECEL_RST;
         cur_r.max_speed_limit <= srls_pkg::MAXLIM_RST;
         cur_r.forward_speed_limit <= srls_pkg::DIRLIM_RST;
         cur_r.reverse_speed_limit <= srls_pkg::DIRLIM_RST;
         cur_r.clamp_mode_select <= srls_pkg::CLMODE_RST;
         cur_r.clamp_speed_threshold <= srls_pkg::CLTHR_RST;
         cur_r.rotation_threshold <= srls_pkg::ROTTHR_RST;
         cur_r.standstill_threshold <= srls_pkg::ZSTHR_RST;
         cur_r.match_threshold <= srls_pkg::MATTHR_RST;
         cur_r.reached_threshold <= srls_pkg::REATHR_RST;
         cur_r.output_function_select <= srls_pkg::DOSEL_RST;
         cur_r.digital_cmd <= srls_pkg::DIGCMD_RST;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign prdata = cur_r.prdata;
   assign pready = cur_r.pready;
   assign pslverr = cur_r.pslverr;
   assign speed_cmd_out = cur_r.cmd_out;
   assign position_lock_out = cur_r.lock;
   assign rotation_detect_out = cur_r.stat[srls_pkg::ST_ROT];
   assign standstill_out = cur_r.stat[srls_pkg::ST_ZERO];
   assign speed_match_out = cur_r.stat[srls_pkg::ST_MATCH];
   assign speed_reached_out = cur_r.stat[srls_pkg::ST_REACH];
   assign digital_out = cur_r.dout;
endmodule
`default_nettype wire

// ===== hdl/srls_pkg.sv
// Constants, register map and encodings for the speed ramp, limit and
// status block. Assumes an APB master on a 40 MHz pclk.
package srls_pkg;
   localparam logic [7:0] ADDR_ACCEL = 8'h00;
   localparam logic [7:0] ADDR_DECEL = 8'h04;
   localparam logic [7:0] ADDR_MAXLIM = 8'h08;
   localparam logic [7:0] ADDR_FWDLIM = 8'h0C;
   localparam logic [7:0] ADDR_REVLIM = 8'h10;
   localparam logic [7:0] ADDR_CLMODE = 8'h14;
   localparam logic [7:0] ADDR_CLTHR = 8'h18;
   localparam logic [7:0] ADDR_ROTTHR = 8'h1C;
   localparam logic [7:0] ADDR_ZSTHR = 8'h20;
   localparam logic [7:0] ADDR_MATTHR = 8'h24;
   localparam logic [7:0] ADDR_REATHR = 8'h28;
   localparam logic [7:0] ADDR_DOSEL = 8'h2C;
   localparam logic [7:0] ADDR_DOPOL = 8'h30;
   localparam logic [7:0] ADDR_SRCSEL = 8'h34;
   localparam logic [7:0] ADDR_DIGCMD = 8'h38;
   localparam logic [7:0] ADDR_STATUS = 8'h3C;
   localparam logic [7:0] ADDR_RAMPED = 8'h40;
   localparam logic [15:0] ACCEL_RST = 16'h0032;
   localparam logic [15:0] DECEL_RST = 16'h0032;
   localparam logic [12:0] MAXLIM_RST = 13'h0E10;
   localparam logic [12:0] MAXLIM_MAX = 13'h1388;
   localparam logic [12:0] DIRLIM_RST = 13'h0BB8;
   localparam logic [12:0] DIRLIM_MAX = 13'h0BB8;
   localparam logic [1:0] CLMODE_RST = 2'h0;
   localparam logic [12:0] CLTHR_RST = 13'h0014;
   localparam logic [12:0] THR1000_MAX = 13'h03E8;
   localparam logic [12:0] ROTTHR_RST = 13'h0014;
   localparam logic [12:0] ZSTHR_RST = 13'h000A;
   localparam logic [12:0] ZSTHR_MAX = 13'h1770;
   localparam logic [12:0] MATTHR_RST = 13'h000A;
   localparam logic [12:0] MATTHR_MAX = 13'h0064;
   localparam logic [12:0] REATHR_RST = 13'h0064;
   localparam logic [12:0] REATHR_MIN = 13'h000A;
   localparam logic [7:0] DOSEL_RST = 8'h83;
   localparam logic [7:0] DOSEL_MIN = 8'h80;
   localparam logic [7:0] DOSEL_MAX = 8'h8E;
   localparam logic [7:0] FN_ROTATE = 8'h84;
   localparam logic [7:0] FN_ZERO = 8'h85;
   localparam logic [7:0] FN_MATCH = 8'h87;
   localparam logic [7:0] FN_REACHED = 8'h88;
   localparam logic [13:0] DIGCMD_RST = 14'h0064;
   localparam int SPEED_UNIT_RPM = 1000;
   localparam int CLK_HZ = 40000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
   localparam logic [1:0] CM_FORCE = 2'h0;
   localparam logic [1:0] CM_ACTUAL = 2'h1;
   localparam logic [1:0] CM_CMD = 2'h2;
   localparam logic [1:0] CM_OFF = 2'h3;
   localparam int ST_ROT = 0;
   localparam int ST_ZERO = 1;
   localparam int ST_MATCH = 2;
   localparam int ST_REACH = 3;
   localparam int ST_LOCK = 4;
endpackage

// ===== verif/speed_ramp_limit_status_test.sv
// Self-checking bench for the speed ramp, limit and status block.
// Assumes srls_core with a 40-cycle tick and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   bad_count++; $display("[ERR] %0t got %0h want %0h", $time, a, b); \
   end end
module speed_ramp_limit_status_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic signed [13:0] analog_speed_cmd, actual_speed, filtered_speed;
   logic signed [13:0] speed_cmd_out;
   logic zero_clamp_input, position_lock_out, rotation_detect_out;
   logic standstill_out, speed_match_out, speed_reached_out;
   logic digital_out, host_level;
   int bad_count, total_checks;
   srls_core #(.TICK_CYC(40), .MOTOR_MAX_RPM(13'h0A8C)) u_srls_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .analog_speed_cmd(analog_speed_cmd), .actual_speed(actual_speed),
      .filtered_speed(filtered_speed), .zero_clamp_input(zero_clamp_input),
      .speed_cmd_out(speed_cmd_out), .position_lock_out(position_lock_out),
      .rotation_detect_out(rotation_detect_out),
      .standstill_out(standstill_out), .speed_match_out(speed_match_out),
      .speed_reached_out(speed_reached_out), .digital_out(digital_out));
   srls_host_model u_srls_host_model (.pclk(pclk), .presetn(presetn),
      .digital_out(digital_out), .host_level(host_level));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("[ERR] %0t no pready", $time);
         complete_run();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input int e);
      apb(1'b0, a, 0);
      `CHK(rdat, 32'(e))
   endtask
   task automatic tick(input int n);
      repeat (n * 40) @(posedge pclk);
   endtask
   task automatic spd(input int e);
      `CHK(speed_cmd_out, 14'(e))
   endtask
   task automatic st(input int a, input int f, input logic [3:0] e);
      actual_speed <= 14'(a);
      filtered_speed <= 14'(f);
      repeat (3) @(posedge pclk);
      `CHK({rotation_detect_out, standstill_out, speed_match_out,
         speed_reached_out}, e)
   endtask
   task automatic t_defaults();
      rd(srls_pkg::ADDR_ACCEL, 50);
      rd(srls_pkg::ADDR_DECEL, 50);
      rd(srls_pkg::ADDR_MAXLIM, 3600);
      rd(srls_pkg::ADDR_FWDLIM, 3000);
      rd(srls_pkg::ADDR_REVLIM, 3000);
      rd(srls_pkg::ADDR_CLMODE, 0);
      rd(srls_pkg::ADDR_CLTHR, 20);
      rd(srls_pkg::ADDR_ROTTHR, 20);
      rd(srls_pkg::ADDR_ZSTHR, 10);
      rd(srls_pkg::ADDR_MATTHR, 10);
      rd(srls_pkg::ADDR_REATHR, 100);
      rd(srls_pkg::ADDR_DOSEL, 131);
      rd(srls_pkg::ADDR_SRCSEL, 0);
      rd(8'h44, 0);
      `CHK(rerr, 1'b1)
      $display("defaults done");
   endtask
   task automatic t_ramp();
      wr(srls_pkg::ADDR_ACCEL, 0);
      wr(srls_pkg::ADDR_DECEL, 0);
      wr(srls_pkg::ADDR_DIGCMD, 0);
      tick(2);
      spd(0);
      wr(srls_pkg::ADDR_ACCEL, 10);
      wr(srls_pkg::ADDR_DIGCMD, 1000);
      tick(5);
      `CHK(speed_cmd_out inside {[400:600]}, 1'b1)
      tick(7);
      spd(1000);
      wr(srls_pkg::ADDR_DECEL, 20);
      wr(srls_pkg::ADDR_DIGCMD, 0);
      tick(10);
      `CHK(speed_cmd_out inside {[400:600]}, 1'b1)
      tick(12);
      spd(0);
      wr(srls_pkg::ADDR_ACCEL, 0);
      wr(srls_pkg::ADDR_DECEL, 0);
      wr(srls_pkg::ADDR_DIGCMD, -500);
      tick(2);
      spd(-500);
      $display("ramp done");
   endtask
   task automatic t_limits();
      wr(srls_pkg::ADDR_MAXLIM, 6000);
      rd(srls_pkg::ADDR_MAXLIM, 5000);
      wr(srls_pkg::ADDR_FWDLIM, 4000);
      rd(srls_pkg::ADDR_FWDLIM, 3000);
      wr(srls_pkg::ADDR_FWDLIM, 800);
      wr(srls_pkg::ADDR_REVLIM, 700);
      wr(srls_pkg::ADDR_DIGCMD, 2000);
      tick(2);
      spd(800);
      wr(srls_pkg::ADDR_DIGCMD, -2000);
      tick(2);
      spd(-700);
      wr(srls_pkg::ADDR_MAXLIM, 500);
      tick(2);
      spd(-500);
      wr(srls_pkg::ADDR_MAXLIM, 3600);
      wr(srls_pkg::ADDR_FWDLIM, 3000);
      wr(srls_pkg::ADDR_DIGCMD, 2900);
      tick(2);
      spd(2700);
      $display("limits done");
   endtask
   task automatic t_clamp();
      wr(srls_pkg::ADDR_CLMODE, 2);
      wr(srls_pkg::ADDR_DIGCMD, 10);
      zero_clamp_input <= 1'b1;
      tick(2);
      `CHK({position_lock_out, speed_cmd_out}, 15'h4000)
      wr(srls_pkg::ADDR_DIGCMD, 500);
      tick(2);
      `CHK({position_lock_out, speed_cmd_out}, 15'h01F4)
      wr(srls_pkg::ADDR_CLMODE, 3);
      wr(srls_pkg::ADDR_DIGCMD, 10);
      tick(2);
      `CHK({position_lock_out, speed_cmd_out}, 15'h000A)
      wr(srls_pkg::ADDR_CLMODE, 0);
      wr(srls_pkg::ADDR_DIGCMD, 500);
      tick(2);
      spd(0);
      wr(srls_pkg::ADDR_CLMODE, 1);
      actual_speed <= 14'sh01F4;
      tick(2);
      `CHK({position_lock_out, speed_cmd_out}, 15'h0000)
      actual_speed <= 14'sh0005;
      tick(1);
      `CHK(position_lock_out, 1'b1)
      zero_clamp_input <= 1'b0;
      actual_speed <= 14'sh0000;
      tick(2);
      `CHK({position_lock_out, speed_cmd_out}, 15'h01F4)
      $display("clamp done");
   endtask
   task automatic t_status();
      logic [7:0] fn [4];
      fn = '{srls_pkg::FN_ROTATE, srls_pkg::FN_ZERO, srls_pkg::FN_MATCH,
         srls_pkg::FN_REACHED};
      st(20, 510, 4'hB);
      st(19, 511, 4'h1);
      st(-9, 100, 4'h4);
      st(-10, -101, 4'h1);
      st(-20, 495, 4'hB);
      for (int i = 0; i < 4; i++) begin
         wr(srls_pkg::ADDR_DOSEL, int'(fn[i]));
         for (int p = 0; p < 2; p++) begin
            wr(srls_pkg::ADDR_DOPOL, p);
            repeat (3) @(posedge pclk);
            `CHK(host_level, 4'hB >> (3 - i) & 1'b1 ^ p[0])
         end
      end
      wr(srls_pkg::ADDR_DOSEL, 200);
      rd(srls_pkg::ADDR_DOSEL, int'(srls_pkg::FN_REACHED));
      $display("status done");
   endtask
   task automatic t_source();
      wr(srls_pkg::ADDR_SRCSEL, 1);
      rd(srls_pkg::ADDR_SRCSEL, 0);
      wr(srls_pkg::ADDR_DIGCMD, 0);
      actual_speed <= 14'sh0000;
      tick(2);
      wr(srls_pkg::ADDR_SRCSEL, 1);
      rd(srls_pkg::ADDR_SRCSEL, 1);
      analog_speed_cmd <= 14'sh012C;
      tick(2);
      spd(300);
      rd(srls_pkg::ADDR_RAMPED, 300);
      rd(srls_pkg::ADDR_STATUS, 10);
      $display("source done");
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, zero_clamp_input} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {analog_speed_cmd, actual_speed, filtered_speed} = 42'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_defaults();
      t_ramp();
      t_limits();
      t_clamp();
      t_status();
      t_source();
      complete_run();
   end
endmodule
`default_nettype wire

// ===== verif/srls_checker.sv
// Port-level checker for the speed ramp, limit and status block.
// Assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/1ps
`default_nettype none
module srls_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB answer
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Speeds and clamp
   input wire logic signed [13:0] actual_speed,
   input wire logic signed [13:0] filtered_speed,
   input wire logic zero_clamp_input,
   // Command and status
   input wire logic signed [13:0] speed_cmd_out,
   input wire logic position_lock_out,
   input wire logic rotation_detect_out,
   input wire logic standstill_out,
   input wire logic speed_match_out,
   input wire logic speed_reached_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [14:0] act_mag;
   logic [14:0] filt_mag;
   logic signed [14:0] diff;
   logic [14:0] diff_mag;
   assign act_mag = actual_speed < 0 ? -15'(actual_speed) : 15'(actual_speed);
   assign filt_mag = filtered_speed < 0 ? -15'(filtered_speed)
      : 15'(filtered_speed);
   assign diff = 15'(filtered_speed) - 15'(speed_cmd_out);
   assign diff_mag = diff < 0 ? 15'(-diff) : 15'(diff);
   bus_answer_a: assert property (psel && !penable |=> pready)
      else $error("no answer in access cycle");
   bus_error_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   cmd_limit_a: assert property (
      speed_cmd_out <= 3000 && speed_cmd_out >= -3000)
      else $error("command beyond direction limit");
   lock_zero_a: assert property (
      position_lock_out && $past(position_lock_out) |-> speed_cmd_out == 0)
      else $error("command moves while locked");
   lock_clamp_a: assert property (
      !$past(zero_clamp_input) |-> !position_lock_out)
      else $error("lock without clamp input");
   rot_bound_a: assert property (
      !rotation_detect_out |-> $past(act_mag) < 1000)
      else $error("rotation missed");
   zero_bound_a: assert property (
      standstill_out |-> $past(act_mag) < 6000)
      else $error("standstill at high speed");
   match_bound_a: assert property (
      speed_match_out |-> $past(diff_mag) <= 100)
      else $error("match with large difference");
   reach_bound_a: assert property (
      speed_reached_out |-> $past(filt_mag) > 10)
      else $error("reached at low speed");
endmodule
bind srls_core srls_checker u_srls_checker (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .actual_speed(actual_speed), .filtered_speed(filtered_speed),
   .zero_clamp_input(zero_clamp_input), .speed_cmd_out(speed_cmd_out),
   .position_lock_out(position_lock_out),
   .rotation_detect_out(rotation_detect_out),
   .standstill_out(standstill_out), .speed_match_out(speed_match_out),
   .speed_reached_out(speed_reached_out));
`default_nettype wire

// ===== verif/srls_host_model.sv
// Host controller side: samples the drive's digital output pin.
// Assumes the pin is a plain level on the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module srls_host_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Drive output pin
   input wire logic digital_out,
   // Level seen by the host
   output logic host_level
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_level <= 1'b0;
      end else begin
         host_level <= digital_out;
      end
   end
endmodule
`default_nettype wire
